// [design/grir_regs.vh]
// register offsets, field positions and reset values of the global reset and interrupt bank
// assumes an 8-bit address and 8-bit data register port
`ifndef GRIR_REGS_VH
`define GRIR_REGS_VH

`define GRIR_ADDR_W            8
`define GRIR_DATA_W            8

`define GRIR_OFF_GLOBAL_CTRL   8'hf0
`define GRIR_OFF_LIU_RESET     8'hf5
`define GRIR_OFF_FRM_RESET     8'hf6
`define GRIR_OFF_PART_CODE     8'hf8
`define GRIR_OFF_FRM_STATUS    8'hf9
`define GRIR_OFF_TST_STATUS    8'hfa
`define GRIR_OFF_LIU_STATUS    8'hfb
`define GRIR_OFF_FRM_MASK      8'hfc
`define GRIR_OFF_TST_MASK      8'hfd
`define GRIR_OFF_LIU_MASK      8'hfe

`define GRIR_BIT_RESET         0
`define GRIR_BIT_FLAG          0
`define GRIR_BIT_INHIBIT       0

`define GRIR_RST_VAL           8'h00
`define GRIR_UNMAPPED_VAL      8'h00

`endif

// [design/grir_sync2.v]
// two-stage synchroniser for a group of level inputs
// assumes levels arriving from other clock domains or pins
`timescale 1ns/1ps
module grir_sync2 #(
  parameter W = 3
) (
  // clock and reset
  input  wire         clk_sys_in,
  input  wire         rst_b_in,
  // levels
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_q;

  // first stage read only by second stage
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_q   <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // grir_sync2

// [design/grir_top.v]
// global reset and interrupt register bank of a single-channel line transceiver
// assumes a synchronous single-cycle register port on clk_sys_in; unit irq lines may be asynchronous
`timescale 1ns/1ps
`include "grir_regs.vh"
module grir_top #(
  parameter [4:0] PART_CODE    = 5'h15, // arbitrary neutral value
  parameter [2:0] DIE_REVISION = 3'h1   // arbitrary neutral value
) (
  // clock and reset
  input  wire                    clk_sys_in,
  input  wire                    rst_b_in,
  // register port
  input  wire                    reg_sel_in,
  input  wire                    reg_wr_in,
  input  wire [`GRIR_ADDR_W-1:0] reg_addr_in,
  input  wire [`GRIR_DATA_W-1:0] reg_wdata_in,
  output reg  [`GRIR_DATA_W-1:0] reg_rdata_out,
  output reg                     reg_rvalid_out,
  // unit interrupt requests, active high levels
  input  wire                    framer_irq_in,
  input  wire                    tester_irq_in,
  input  wire                    line_iface_irq_in,
  // unit resets, active high levels
  output reg                     line_iface_rst_out,
  output reg                     framer_tester_rst_out,
  // interrupt pin, active low
  output reg                     irq_out_n
);

  // software state
  reg line_iface_reset_bit_q;
  reg framer_reset_bit_q;
  reg framer_irq_enable_q;
  reg tester_irq_enable_q;
  reg line_iface_irq_enable_q;
  reg global_irq_inhibit_q;

  // status flags, live copies of unit irqs
  reg framer_irq_flag_q;
  reg tester_irq_flag_q;
  reg line_iface_irq_flag_q;

  wire [2:0] irq_sync;
  wire       wr_hit;
  wire       rd_hit;
  wire       irq_any;
  reg  [`GRIR_DATA_W-1:0] rdata_d;

  // unit irqs come from other logic, resynchronise before use
  grir_sync2 #(
    .W (3)
  ) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .async_in   ({line_iface_irq_in, tester_irq_in, framer_irq_in}),
    .sync_out   (irq_sync)
  );

  assign wr_hit = reg_sel_in & reg_wr_in;
  assign rd_hit = reg_sel_in & ~reg_wr_in;

  // writable control bits; only bit 0 of each register is stored
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_iface_reset_bit_q  <= 1'b0;
      framer_reset_bit_q      <= 1'b0;
      framer_irq_enable_q     <= 1'b0;
      tester_irq_enable_q     <= 1'b0;
      line_iface_irq_enable_q <= 1'b0;
      global_irq_inhibit_q    <= 1'b0;
    end else if (wr_hit) begin
      case (reg_addr_in)
        `GRIR_OFF_LIU_RESET: begin
          line_iface_reset_bit_q <= reg_wdata_in[`GRIR_BIT_RESET];
        end
        `GRIR_OFF_FRM_RESET: begin
          framer_reset_bit_q <= reg_wdata_in[`GRIR_BIT_RESET];
        end
        `GRIR_OFF_FRM_MASK: begin
          framer_irq_enable_q <= reg_wdata_in[`GRIR_BIT_FLAG];
        end
        `GRIR_OFF_TST_MASK: begin
          tester_irq_enable_q <= reg_wdata_in[`GRIR_BIT_FLAG];
        end
        `GRIR_OFF_LIU_MASK: begin
          line_iface_irq_enable_q <= reg_wdata_in[`GRIR_BIT_FLAG];
        end
        `GRIR_OFF_GLOBAL_CTRL: begin
          global_irq_inhibit_q <= reg_wdata_in[`GRIR_BIT_INHIBIT];
        end
        default: begin
          // writes to read-only or unmapped offsets are dropped
        end
      endcase
    end
  end

  // unit resets follow the stored bit: asserted on 0-to-1, held until a 0 is written
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      line_iface_rst_out    <= 1'b0;
      framer_tester_rst_out <= 1'b0;
    end else begin
      line_iface_rst_out    <= line_iface_reset_bit_q;
      framer_tester_rst_out <= framer_reset_bit_q;
    end
  end

  // status flags track the units with no clear action, so an event shows only while its unit irq stays high
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      framer_irq_flag_q     <= 1'b0;
      tester_irq_flag_q     <= 1'b0;
      line_iface_irq_flag_q <= 1'b0;
    end else begin
      framer_irq_flag_q     <= irq_sync[0];
      tester_irq_flag_q     <= irq_sync[1];
      line_iface_irq_flag_q <= irq_sync[2];
    end
  end

  // masked or of the three flags
  assign irq_any = (framer_irq_flag_q & framer_irq_enable_q)
                 | (tester_irq_flag_q & tester_irq_enable_q)
                 | (line_iface_irq_flag_q & line_iface_irq_enable_q);

  // pin driven from a flop; inhibit wins so software can silence it globally
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_out_n <= 1'b1;
    end else begin
      irq_out_n <= global_irq_inhibit_q | ~irq_any;
    end
  end

  // read mux; reserved bits read zero
  always @* begin
    rdata_d = `GRIR_UNMAPPED_VAL;
    case (reg_addr_in)
      `GRIR_OFF_GLOBAL_CTRL: rdata_d[`GRIR_BIT_INHIBIT] = global_irq_inhibit_q;
      `GRIR_OFF_LIU_RESET:   rdata_d[`GRIR_BIT_RESET]   = line_iface_reset_bit_q;
      `GRIR_OFF_FRM_RESET:   rdata_d[`GRIR_BIT_RESET]   = framer_reset_bit_q;
      `GRIR_OFF_PART_CODE:   rdata_d = {PART_CODE, DIE_REVISION};
      `GRIR_OFF_FRM_STATUS:  rdata_d[`GRIR_BIT_FLAG]    = framer_irq_flag_q;
      `GRIR_OFF_TST_STATUS:  rdata_d[`GRIR_BIT_FLAG]    = tester_irq_flag_q;
      `GRIR_OFF_LIU_STATUS:  rdata_d[`GRIR_BIT_FLAG]    = line_iface_irq_flag_q;
      `GRIR_OFF_FRM_MASK:    rdata_d[`GRIR_BIT_FLAG]    = framer_irq_enable_q;
      `GRIR_OFF_TST_MASK:    rdata_d[`GRIR_BIT_FLAG]    = tester_irq_enable_q;
      `GRIR_OFF_LIU_MASK:    rdata_d[`GRIR_BIT_FLAG]    = line_iface_irq_enable_q;
      default:               rdata_d = `GRIR_UNMAPPED_VAL;
    endcase
  end

  // registered read answer, one cycle after the request
  always @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out  <= `GRIR_RST_VAL;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= rd_hit;
      if (rd_hit) begin
        reg_rdata_out <= rdata_d;
      end
    end
  end

endmodule // grir_top

// [sim/grir_chk.sv]
// checker for the global reset and interrupt bank, port view only
// assumes grir_top on one clock with asynchronous active-low reset
`timescale 1ns/1ps
module grir_chk #(
  parameter [4:0] PART_CODE    = 5'h15, // arbitrary value
  parameter [2:0] DIE_REVISION = 3'h1   // arbitrary value
) (
  // clock and reset
  input logic       clk_sys_in,
  input logic       rst_b_in,
  // register port
  input logic       reg_sel_in,
  input logic       reg_wr_in,
  input logic [7:0] reg_addr_in,
  input logic [7:0] reg_wdata_in,
  input logic [7:0] reg_rdata_out,
  input logic       reg_rvalid_out,
  // unit irqs, resets and pin
  input logic       framer_irq_in,
  input logic       tester_irq_in,
  input logic       line_iface_irq_in,
  input logic       line_iface_rst_out,
  input logic       framer_tester_rst_out,
  input logic       irq_out_n
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // request decode and any-unit irq
  wire rd_req  = reg_sel_in && !reg_wr_in;
  wire wr_req  = reg_sel_in && reg_wr_in;
  wire any_irq = framer_irq_in || tester_irq_in || line_iface_irq_in;
  property p_id; rd_req && reg_addr_in == 8'hf8 |=> reg_rvalid_out && reg_rdata_out == {PART_CODE, DIE_REVISION}; endproperty
  a_id: assert property (p_id) else $error("part code read wrong");
  property p_lrst; wr_req && reg_addr_in == 8'hf5 |-> ##2 line_iface_rst_out == $past(reg_wdata_in[0], 2); endproperty
  a_lrst: assert property (p_lrst) else $error("line reset out wrong");
  property p_frst; wr_req && reg_addr_in == 8'hf6 |-> ##2 framer_tester_rst_out == $past(reg_wdata_in[0], 2); endproperty
  a_frst: assert property (p_frst) else $error("framer reset out wrong");
  // status only judged once the input has settled past the synchroniser
  property p_fst; $stable(framer_irq_in)[*4] ##0 (rd_req && reg_addr_in == 8'hf9) |=> reg_rdata_out == {7'h00, $past(framer_irq_in)}; endproperty
  a_fst: assert property (p_fst) else $error("framer flag wrong");
  property p_tst; $stable(tester_irq_in)[*4] ##0 (rd_req && reg_addr_in == 8'hfa) |=> reg_rdata_out == {7'h00, $past(tester_irq_in)}; endproperty
  a_tst: assert property (p_tst) else $error("tester flag wrong");
  property p_lst; $stable(line_iface_irq_in)[*4] ##0 (rd_req && reg_addr_in == 8'hfb) |=> reg_rdata_out == {7'h00, $past(line_iface_irq_in)}; endproperty
  a_lst: assert property (p_lst) else $error("line flag wrong");
  property p_irq; !irq_out_n |-> $past(any_irq, 3) || $past(any_irq, 4) || $past(any_irq, 5); endproperty
  a_irq: assert property (p_irq) else $error("irq pin low without cause");
  property p_msk; (wr_req && reg_addr_in == 8'hfc && !reg_wdata_in[0]) ##1 (!tester_irq_in && !line_iface_irq_in)[*6] |-> irq_out_n; endproperty
  a_msk: assert property (p_msk) else $error("masked framer irq reached pin");
endmodule // grir_chk
bind grir_top grir_chk #(.PART_CODE(PART_CODE), .DIE_REVISION(DIE_REVISION)) i_grir_chk (.clk_sys_in, .rst_b_in,
  .reg_sel_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .framer_irq_in,
  .tester_irq_in, .line_iface_irq_in, .line_iface_rst_out, .framer_tester_rst_out, .irq_out_n);

// [sim/tb.sv]
// self-checking bench for the global reset and interrupt bank
// assumes grir_top with a single-cycle register port at 200 MHz
`timescale 1ns/1ps
module tb;
  localparam [4:0] PC = 5'h0a; // arbitrary value
  localparam [2:0] DR = 3'h5;  // arbitrary value
  logic       clk_sys_in = 0, rst_b_in = 0, sel = 0, wr = 0, rvalid, lrst, frst, irq_n;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [2:0] irq = 3'h0;
  int         fails = 0, checks_done = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  grir_top #(.PART_CODE(PC), .DIE_REVISION(DR)) i_grir_top (.clk_sys_in, .rst_b_in, .reg_sel_in(sel),
    .reg_wr_in(wr), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .framer_irq_in(irq[0]), .tester_irq_in(irq[1]), .line_iface_irq_in(irq[2]), .line_iface_rst_out(lrst),
    .framer_tester_rst_out(frst), .irq_out_n(irq_n));
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // spare cycle after the strobe so it never flips twice in a step
  task automatic wreg(input logic [7:0] a, d);
    sel = 1;
    wr = 1;
    addr = a;
    wdata = d;
    tick(1);
    sel = 0;
    tick(1);
  endtask
  task automatic rchk(input logic [7:0] a, exp);
    int n;
    sel = 1;
    wr = 0;
    addr = a;
    tick(1);
    sel = 0;
    for (n = 0; n < 3 && rvalid !== 1'b1; n++) tick(1);
    cmp({7'h00, rvalid}, 8'h01);
    cmp(rdata, exp);
    tick(1);
  endtask
  task automatic t_regs;
    for (logic [8:0] a = 9'h0f0; a < 9'h100; a++) rchk(a[7:0], a == 9'h0f8 ? {PC, DR} : 8'h00);
    wreg(8'hf8, 8'hff);
    rchk(8'hf8, {PC, DR});
    wreg(8'h10, 8'hff);
    rchk(8'h10, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_rst;
    for (logic [7:0] j = 0; j < 2; j++) begin
      wreg(8'hf5 + j, 8'hff);
      cmp({6'h00, frst, lrst}, 8'h01 << j);
      wreg(8'hf5 + j, 8'h01);
      cmp({6'h00, frst, lrst}, 8'h01 << j);
      rchk(8'hf5 + j, 8'h01);
      wreg(8'hf5 + j, 8'h00);
      cmp({6'h00, frst, lrst}, 8'h00);
    end
    $display("t_rst done");
  endtask
  // each unit: flag, mask off, mask on, inhibit, release
  task automatic t_irq;
    for (logic [7:0] u = 0; u < 3; u++) begin
      irq = 3'h1 << u;
      tick(5);
      rchk(8'hf9 + u, 8'h01);
      cmp({7'h00, irq_n}, 8'h01);
      wreg(8'hfc + u, 8'h01);
      tick(1);
      cmp({7'h00, irq_n}, 8'h00);
      wreg(8'hf0, 8'h01);
      tick(1);
      cmp({7'h00, irq_n}, 8'h01);
      wreg(8'hf0, 8'h00);
      irq = 3'h0;
      tick(5);
      cmp({7'h00, irq_n}, 8'h01);
      rchk(8'hf9 + u, 8'h00);
      wreg(8'hfc + u, 8'h00);
      tick(8);
    end
    $display("t_irq done");
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    tick(10);
    rst_b_in = 1;
    tick(1);
    t_regs;
    t_rst;
    t_irq;
    finish_test;
  end
  // whole run needs about 165 cycles
  initial begin
    #20000;
    fails++;
    finish_test;
  end
endmodule // tb
